// ---- omc_checker.sv ----
// pin-level assertions for the management block
`timescale 1ns/1ns
`default_nettype none
module omc_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic deselect,
  input wire logic laser_off_request,
  input wire logic power_down,
  input wire logic rx_detect_lost,
  input wire logic interrupt_n,
  input wire logic module_absent,
  input wire logic not_ready_flag,
  input wire logic rx_signal_lost,
  input wire logic laser_enable,
  input wire logic standby
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_absent_low: assert property (!module_absent)
    else $error("absence output not low");
  a_laser_cut: assert property ($rose(laser_off_request) |-> ##3 !laser_enable)
    else $error("laser not cut in time");
  // eight quiet cycles ride out the one-cycle reset after a power-down fall
  a_laser_back: assert property ((!laser_off_request && !power_down) [*8] |=> laser_enable)
    else $error("laser not back on");
  a_standby_held: assert property (power_down [*4] |=> standby && !laser_enable)
    else $error("stand-by not held");
  a_pdown_reset: assert property ($fell(power_down) |-> ##[3:6] not_ready_flag)
    else $error("no reset after power-down fall");
  a_los_set: assert property ((rx_detect_lost && !power_down) [*8] |=> rx_signal_lost && !interrupt_n)
    else $error("loss of signal not flagged");
  a_los_clear: assert property ((!rx_detect_lost && !power_down) [*8] |=> !rx_signal_lost)
    else $error("loss of signal stuck");
  a_desel_quiet: assert property (deselect [*4] |=> !sda_oe)
    else $error("data driven while deselected");
  a_drive_low: assert property ($rose(sda_oe) |-> !$past(scl, 2))
    else $error("data driven outside clock low");
  a_hold_high: assert property (scl [*4] |-> $stable(sda_oe))
    else $error("data moved while clock high");
endmodule // omc_checker
bind omc_top omc_checker chk (.clk, .resetn, .scl, .sda_oe, .deselect, .laser_off_request,
  .power_down, .rx_detect_lost, .interrupt_n, .module_absent, .not_ready_flag,
  .rx_signal_lost, .laser_enable, .standby);
`default_nettype wire

// ---- omc_host.sv ----
// host-side two-wire master model
`timescale 1ns/1ns
`default_nettype none
module omc_host (
  output logic scl,
  output logic pull,
  input wire logic sda,
  output logic got,
  output logic [8:0] got_val
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    got = 1'b0;
    got_val = '0;
  end
  task automatic bit_out(input logic b);
    pull = ~b;
    #100 scl = 1'b1;
    #200 scl = 1'b0;
    #100;
  endtask
  task automatic bit_in(output logic b);
    pull = 1'b0;
    #100 scl = 1'b1;
    #100 b = sda;
    #100 scl = 1'b0;
    #100;
  endtask
  // serves as repeated start as well
  task automatic start();
    pull = 1'b0;
    #100 scl = 1'b1;
    #100 pull = 1'b1;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic stop();
    pull = 1'b1;
    #100 scl = 1'b1;
    #100 pull = 1'b0;
    #100;
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    got_val = {~a, 8'h00};
    got = ~got;
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
    got_val = {1'b0, d};
    got = ~got;
  endtask
endmodule // omc_host
`default_nettype wire

// ---- omc_pkg.sv ----
// constants, address map and state codes for the optical module management block
package omc_pkg;
  // monitored channels: 0 temperature, 1 laser bias, 2 tx power, 3 rx power, 4 supply
  localparam int OMC_CHANNELS = 5;
  localparam int OMC_VALUE_W = 16;
  localparam int OMC_FLAG_GROUPS = 4;
  // serial slave address
  localparam logic [6:0] OMC_DEV_ADDR = 7'h50;
  // byte address map
  localparam logic [7:0] OMC_ADDR_MON_BASE = 8'h00;
  localparam logic [7:0] OMC_ADDR_ALARM_HI = 8'h0A;
  localparam logic [7:0] OMC_ADDR_ALARM_LO = 8'h0B;
  localparam logic [7:0] OMC_ADDR_WARN_HI = 8'h0C;
  localparam logic [7:0] OMC_ADDR_WARN_LO = 8'h0D;
  localparam logic [7:0] OMC_ADDR_STATUS = 8'h0E;
  localparam logic [7:0] OMC_ADDR_USER_BASE = 8'h80;
  localparam int OMC_RAM_AW = 7;
  localparam int OMC_BYTE_W = 8;
  // flag group index inside the latched flag array
  localparam int OMC_FG_ALARM_HI = 0;
  localparam int OMC_FG_ALARM_LO = 1;
  localparam int OMC_FG_WARN_HI = 2;
  localparam int OMC_FG_WARN_LO = 3;
  // factory limits per channel, unsigned codes
  localparam logic [15:0] OMC_ALARM_HI_LIM [OMC_CHANNELS] =
    '{16'hE000, 16'hD000, 16'hD000, 16'hD000, 16'hE800};
  localparam logic [15:0] OMC_WARN_HI_LIM [OMC_CHANNELS] =
    '{16'hC000, 16'hB000, 16'hB000, 16'hB000, 16'hD800};
  localparam logic [15:0] OMC_WARN_LO_LIM [OMC_CHANNELS] =
    '{16'h2000, 16'h1000, 16'h1000, 16'h1000, 16'h9000};
  localparam logic [15:0] OMC_ALARM_LO_LIM [OMC_CHANNELS] =
    '{16'h1000, 16'h0800, 16'h0800, 16'h0800, 16'h8000};
  // status byte fields
  localparam int OMC_ST_PDOWN = 0;
  localparam int OMC_ST_TXOFF = 1;
  localparam int OMC_ST_LOS = 2;
  localparam int OMC_ST_INT = 3;
  localparam int OMC_ST_NR = 4;
  // synchroniser lanes
  localparam int OMC_SY_SCL = 0;
  localparam int OMC_SY_SDA = 1;
  localparam int OMC_SY_DESEL = 2;
  localparam int OMC_SY_TXOFF = 3;
  localparam int OMC_SY_PDOWN = 4;
  localparam int OMC_SY_LOS = 5;
  localparam int OMC_SYNC_W = 6;
  localparam logic [OMC_SYNC_W-1:0] OMC_SYNC_RESET = 6'h07;
  // cycles of not-ready after any reset
  localparam int OMC_READY_CYCLES = 16;
  // laser switching limit in ms, clock in kHz
  localparam int OMC_LASER_SWITCH_MS = 100;
  localparam int OMC_CLK_KHZ = 20000;
  localparam int OMC_LASER_LIMIT_CYCLES = OMC_LASER_SWITCH_MS * OMC_CLK_KHZ;

  typedef enum logic [8:0] {
    OMC_IDLE      = 9'h001,
    OMC_DEVADDR   = 9'h002,
    OMC_ACK_DEV   = 9'h004,
    OMC_WORD      = 9'h008,
    OMC_ACK_WORD  = 9'h010,
    OMC_WDATA     = 9'h020,
    OMC_ACK_WDATA = 9'h040,
    OMC_RDATA     = 9'h080,
    OMC_RACK      = 9'h100
  } omc_state_t;
endpackage

// ---- omc_ram.sv ----
// user byte memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module omc_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // omc_ram
`default_nettype wire

// ---- omc_sync.sv ----
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module omc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // omc_sync
`default_nettype wire

// ---- omc_top.sv ----
// management and control logic of a pluggable optical module
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - serial commands answered only while deselect low
// - active-low interrupt, cause readable over serial
// - laser off while disable input asserted
// - power-down high holds low-power stand-by
// - power-down falling edge starts module reset
// - that reset equals power cycle, serial included
// - absence output always driven low
// - receiver loss-of-signal status output provided
// - sample SDA on rising SCL, unprotected only
// - drive SDA changes on falling SCL
// - memory is individually addressed 8-bit words
// - random and sequential access from 000h
// - temperature, bias, powers, supply readable
// - alarm/warning flags when outside factory range
// - loss-of-signal: 0 normal, 1 no signal
// - laser on/off within 100 ms
module omc_top
  import omc_pkg::*;
#(
  parameter int READY_CYCLES = omc_pkg::OMC_READY_CYCLES,
  parameter logic [6:0] DEV_ADDR = omc_pkg::OMC_DEV_ADDR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic deselect,
  input wire logic laser_off_request,
  input wire logic power_down,
  input wire logic rx_detect_lost,
  input wire logic [omc_pkg::OMC_VALUE_W-1:0] temp_value,
  input wire logic [omc_pkg::OMC_VALUE_W-1:0] bias_value,
  input wire logic [omc_pkg::OMC_VALUE_W-1:0] tx_power_value,
  input wire logic [omc_pkg::OMC_VALUE_W-1:0] rx_power_value,
  input wire logic [omc_pkg::OMC_VALUE_W-1:0] supply_value,
  output logic interrupt_n,
  output logic module_absent,
  output logic not_ready_flag,
  output logic rx_signal_lost,
  output logic laser_enable,
  output logic standby
);
  import omc_pkg::*;

  localparam int RCW = $clog2(READY_CYCLES + 1);

  logic [OMC_SYNC_W-1:0] pins_s;
  logic pd_prev;
  logic sys_rst_n;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic selected;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  omc_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] sh;
  logic [7:0] addr;
  logic rw;
  logic master_nack;
  logic [7:0] tx_byte;
  logic [7:0] rd_byte;
  logic [7:0] ram_q;
  logic ram_we;
  logic load_tx;
  logic [OMC_VALUE_W-1:0] mon [OMC_CHANNELS];
  logic [OMC_VALUE_W-1:0] mon_in [OMC_CHANNELS];
  logic [OMC_CHANNELS-1:0] live [OMC_FLAG_GROUPS];
  logic [OMC_CHANNELS-1:0] flag_lat [OMC_FLAG_GROUPS];
  logic [OMC_FLAG_GROUPS-1:0] flag_clr;
  logic any_flag;
  logic mon_ok;
  logic [RCW-1:0] ready_cnt;

  omc_sync #(
    .W(OMC_SYNC_W),
    .RST(OMC_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({rx_detect_lost, power_down, laser_off_request, deselect, sda_in, scl}),
    .q(pins_s)
  );

  // power-down edge detector lives on the pin reset so it can drive the module reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_prev <= 1'b0;
      sys_rst_n <= 1'b0;
    end else begin
      pd_prev <= pins_s[OMC_SY_PDOWN];
      // registered so the internal reset never glitches
      sys_rst_n <= ~(pd_prev & ~pins_s[OMC_SY_PDOWN]);
    end
  end

  assign scl_s = pins_s[OMC_SY_SCL];
  assign sda_s = pins_s[OMC_SY_SDA];
  assign selected = ~pins_s[OMC_SY_DESEL];
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign start_ev = selected & scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_ev = selected & scl_s & scl_prev & ~sda_prev & sda_s;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // monitored values, frozen in stand-by
  assign mon_in[0] = temp_value;
  assign mon_in[1] = bias_value;
  assign mon_in[2] = tx_power_value;
  assign mon_in[3] = rx_power_value;
  assign mon_in[4] = supply_value;

  generate
    for (genvar ch = 0; ch < OMC_CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
          mon[ch] <= '0;
        end else if (!pins_s[OMC_SY_PDOWN]) begin
          mon[ch] <= mon_in[ch];
        end
      end
      assign live[OMC_FG_ALARM_HI][ch] = mon[ch] > OMC_ALARM_HI_LIM[ch];
      assign live[OMC_FG_ALARM_LO][ch] = mon[ch] < OMC_ALARM_LO_LIM[ch];
      assign live[OMC_FG_WARN_HI][ch] = mon[ch] > OMC_WARN_HI_LIM[ch];
      assign live[OMC_FG_WARN_LO][ch] = mon[ch] < OMC_WARN_LO_LIM[ch];
    end
  endgenerate

  // latched flags clear when their byte is read; a new event in that cycle wins
  generate
    for (genvar g = 0; g < OMC_FLAG_GROUPS; g++) begin : g_flag
      assign flag_clr[g] = load_tx & (addr == OMC_ADDR_ALARM_HI + 8'(g));
      always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
          flag_lat[g] <= '0;
        end else begin
          flag_lat[g] <= (live[g] & {OMC_CHANNELS{mon_ok}}) |
                         (flag_lat[g] & ~{OMC_CHANNELS{flag_clr[g]}});
        end
      end
    end
  endgenerate

  assign any_flag = (|flag_lat[0]) | (|flag_lat[1]) | (|flag_lat[2]) | (|flag_lat[3]);

  // read data for the current address
  always_comb begin
    rd_byte = 8'h00;
    if (addr[7]) begin
      rd_byte = ram_q;
    end else if (addr < OMC_ADDR_ALARM_HI) begin
      rd_byte = addr[0] ? mon[addr[3:1]][7:0] : mon[addr[3:1]][15:8];
    end else if (addr == OMC_ADDR_ALARM_HI) begin
      rd_byte = {3'h0, flag_lat[OMC_FG_ALARM_HI]};
    end else if (addr == OMC_ADDR_ALARM_LO) begin
      rd_byte = {3'h0, flag_lat[OMC_FG_ALARM_LO]};
    end else if (addr == OMC_ADDR_WARN_HI) begin
      rd_byte = {3'h0, flag_lat[OMC_FG_WARN_HI]};
    end else if (addr == OMC_ADDR_WARN_LO) begin
      rd_byte = {3'h0, flag_lat[OMC_FG_WARN_LO]};
    end else if (addr == OMC_ADDR_STATUS) begin
      rd_byte[OMC_ST_PDOWN] = pins_s[OMC_SY_PDOWN];
      rd_byte[OMC_ST_TXOFF] = pins_s[OMC_SY_TXOFF];
      rd_byte[OMC_ST_LOS] = pins_s[OMC_SY_LOS];
      rd_byte[OMC_ST_INT] = ~interrupt_n;
      rd_byte[OMC_ST_NR] = not_ready_flag;
    end
  end

  assign load_tx = selected & ~start_ev & ~stop_ev & ~scl_rise & scl_fall &
                   (((state == OMC_ACK_DEV) & rw) | ((state == OMC_RACK) & ~master_nack));
  // only the user area takes data; lower bytes stay read-only
  assign ram_we = selected & ~start_ev & ~stop_ev & scl_fall & (state == OMC_WDATA) &
                  (bitcnt == 4'd8) & addr[7];

  omc_ram #(
    .AW(OMC_RAM_AW),
    .DW(OMC_BYTE_W)
  ) u_ram (
    .clk(clk),
    .resetn(sys_rst_n),
    .wr_en(ram_we),
    .wr_addr(addr[6:0]),
    .wr_data(sh),
    .rd_addr(addr[6:0]),
    .rd_data(ram_q)
  );

  // serial slave
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state <= OMC_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      addr <= 8'h00;
      rw <= 1'b0;
      master_nack <= 1'b0;
      tx_byte <= 8'h00;
      sda_oe <= 1'b0;
    end else if (!selected) begin
      state <= OMC_IDLE;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      state <= OMC_DEVADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state <= OMC_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state inside {OMC_DEVADDR, OMC_WORD, OMC_WDATA}) begin
        sh <= {sh[6:0], sda_s};
        bitcnt <= bitcnt + 4'd1;
      end
      if (state == OMC_RACK) begin
        master_nack <= sda_s;
      end
    end else if (scl_fall) begin
      unique case (state)
        OMC_IDLE: begin
          sda_oe <= 1'b0;
        end
        OMC_DEVADDR: begin
          if (bitcnt == 4'd8) begin
            if (sh[7:1] == DEV_ADDR) begin
              rw <= sh[0];
              sda_oe <= 1'b1;
              state <= OMC_ACK_DEV;
            end else begin
              state <= OMC_IDLE;
            end
          end
        end
        OMC_ACK_DEV: begin
          bitcnt <= 4'h0;
          if (rw) begin
            tx_byte <= rd_byte;
            sda_oe <= ~rd_byte[7];
            bitcnt <= 4'd1;
            state <= OMC_RDATA;
          end else begin
            sda_oe <= 1'b0;
            state <= OMC_WORD;
          end
        end
        OMC_WORD: begin
          if (bitcnt == 4'd8) begin
            addr <= sh;
            sda_oe <= 1'b1;
            state <= OMC_ACK_WORD;
          end
        end
        OMC_ACK_WORD: begin
          sda_oe <= 1'b0;
          bitcnt <= 4'h0;
          state <= OMC_WDATA;
        end
        OMC_WDATA: begin
          if (bitcnt == 4'd8) begin
            // protected bytes are still acknowledged
            addr <= addr + 8'd1;
            sda_oe <= 1'b1;
            state <= OMC_ACK_WDATA;
          end
        end
        OMC_ACK_WDATA: begin
          sda_oe <= 1'b0;
          bitcnt <= 4'h0;
          state <= OMC_WDATA;
        end
        OMC_RDATA: begin
          if (bitcnt == 4'd8) begin
            sda_oe <= 1'b0;
            addr <= addr + 8'd1;
            state <= OMC_RACK;
          end else begin
            sda_oe <= ~tx_byte[3'(4'd7 - bitcnt)];
            bitcnt <= bitcnt + 4'd1;
          end
        end
        OMC_RACK: begin
          if (master_nack) begin
            sda_oe <= 1'b0;
            state <= OMC_IDLE;
          end else begin
            tx_byte <= rd_byte;
            sda_oe <= ~rd_byte[7];
            bitcnt <= 4'd1;
            state <= OMC_RDATA;
          end
        end
      endcase
    end
  end

  // not-ready holds for a short settle after every reset and through stand-by
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ready_cnt <= '0;
      not_ready_flag <= 1'b1;
      mon_ok <= 1'b0;
    end else begin
      // zeroed monitors after reset would otherwise latch false low flags
      mon_ok <= mon_ok | ~pins_s[OMC_SY_PDOWN];
      if (ready_cnt != RCW'(READY_CYCLES)) begin
        ready_cnt <= ready_cnt + RCW'(1);
      end
      not_ready_flag <= (ready_cnt != RCW'(READY_CYCLES)) | pins_s[OMC_SY_PDOWN];
    end
  end

  // pin outputs; laser reacts in cycles, far inside the switching limit
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      laser_enable <= 1'b0;
      standby <= 1'b0;
      rx_signal_lost <= 1'b1;
      interrupt_n <= 1'b1;
      module_absent <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      laser_enable <= ~pins_s[OMC_SY_TXOFF] & ~pins_s[OMC_SY_PDOWN];
      standby <= pins_s[OMC_SY_PDOWN];
      rx_signal_lost <= pins_s[OMC_SY_LOS];
      interrupt_n <= ~(any_flag | pins_s[OMC_SY_LOS]);
      module_absent <= 1'b0;
      sda_out <= 1'b0;
    end
  end
endmodule // omc_top
`default_nettype wire

// ---- omc_top_bench.sv ----
// self-checking bench for the management block
`timescale 1ns/1ns
`default_nettype none
module omc_top_bench;
  import omc_pkg::*;
  localparam logic [7:0] WA = {OMC_DEV_ADDR, 1'b0};
  localparam logic [7:0] RA = {OMC_DEV_ADDR, 1'b1};
  logic clk = 0;
  logic resetn = 0;
  logic deselect = 0;
  logic laser_off_request = 0;
  logic power_down = 0;
  logic rx_detect_lost = 0;
  logic [15:0] mon [5];
  logic scl, pull, got, sda_out, sda_oe, interrupt_n, module_absent, not_ready_flag;
  logic rx_signal_lost, laser_enable, standby;
  logic [8:0] got_val;
  logic [7:0] d0, hi, lo;
  logic [8:0] expq [$];
  int n_fail = 0;
  int checked = 0;
  wire sda_line = (sda_oe ? sda_out : 1'b1) & ~pull;
  always #25 clk = ~clk;
  omc_top #(.READY_CYCLES(2)) dut (.clk, .resetn, .scl, .sda_in(sda_line), .sda_out,
    .sda_oe, .deselect, .laser_off_request, .power_down, .rx_detect_lost,
    .temp_value(mon[0]), .bias_value(mon[1]), .tx_power_value(mon[2]),
    .rx_power_value(mon[3]), .supply_value(mon[4]), .interrupt_n, .module_absent,
    .not_ready_flag, .rx_signal_lost, .laser_enable, .standby);
  omc_host host (.scl, .pull, .sda(sda_line), .got, .got_val);
  task check(input logic [8:0] seen, input logic [8:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task stop_test();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // skip the host's power-up value; an empty queue yields an impossible value
  always @(got) begin
    if (resetn) check(got_val, expq.size() > 0 ? expq.pop_front() : 9'h1FF);
  end
  task wr(input logic [7:0] b, input logic ack);
    expq.push_back({ack, 8'h00});
    host.wbyte(b);
  endtask
  task rd(input logic [7:0] e, input logic last);
    expq.push_back({1'b0, e});
    host.rbyte(last);
  endtask
  task point(input logic [7:0] a);
    host.start();
    wr(WA, 1'b1);
    wr(a, 1'b1);
    host.start();
    wr(RA, 1'b1);
  endtask
  function automatic logic [7:0] exp_at(input int a);
    if (a > 9) return 8'h00;
    return a % 2 ? mon[a / 2][7:0] : mon[a / 2][15:8];
  endfunction
  initial begin
    #2_000_000;
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(22979));
    foreach (mon[i]) mon[i] = 16'hA000;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    // kept inside every channel's warning band so no flag latches
    foreach (mon[i]) mon[i] = 16'h9000 + 16'($urandom_range(16'h1FFF));
    // top bit set keeps ~d0 apart from every monitor high byte
    d0 = 8'h80 | 8'($urandom);
    host.start();
    wr(WA, 1'b1);
    wr(8'hFF, 1'b1);
    wr(d0, 1'b1);
    wr(~d0, 1'b1);
    host.stop();
    point(8'hFF);
    rd(d0, 1'b0);
    for (int a = 0; a < 15; a++) rd(exp_at(a), a == 14);
    host.stop();
    for (int c = 0; c < 5; c++) begin
      mon[c] = c % 2 ? 16'h0000 : 16'hFFFF;
      repeat (4) @(negedge clk);
      check({8'h00, interrupt_n}, 9'h000);
      mon[c] = 16'hA000;
      hi = c % 2 ? 8'h00 : 8'(1 << c);
      lo = c % 2 ? 8'(1 << c) : 8'h00;
      point(OMC_ADDR_ALARM_HI);
      rd(hi, 1'b0);
      rd(lo, 1'b0);
      rd(hi, 1'b0);
      rd(lo, 1'b1);
      host.stop();
    end
    check({8'h00, interrupt_n}, 9'h001);
    deselect = 1'b1;
    host.start();
    wr(WA, 1'b0);
    host.stop();
    deselect = 1'b0;
    repeat (4) @(negedge clk);
    host.start();
    wr(WA ^ 8'h02, 1'b0);
    host.stop();
    laser_off_request = 1'b1;
    repeat (4) @(negedge clk);
    check({8'h00, laser_enable}, 9'h000);
    laser_off_request = 1'b0;
    rx_detect_lost = 1'b1;
    repeat (10) @(negedge clk);
    check({7'h00, rx_signal_lost, interrupt_n}, 9'h002);
    rx_detect_lost = 1'b0;
    check({7'h00, module_absent, not_ready_flag}, 9'h000);
    // power-down mid-frame: the reset must drop the half-done transfer
    host.start();
    wr(WA, 1'b1);
    power_down = 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, not_ready_flag, standby, laser_enable}, 9'h006);
    power_down = 1'b0;
    repeat (8) @(negedge clk);
    wr(8'h80, 1'b0);
    host.stop();
    point(8'hFF);
    rd(d0, 1'b1);
    host.stop();
    repeat (10) @(negedge clk);
    check(9'(expq.size()), 9'h000);
    stop_test();
  end
endmodule // omc_top_bench
`default_nettype wire
